// File: vrc_params.svh
// constants for the video dram controller
`ifndef VRC_PARAMS_SVH
`define VRC_PARAMS_SVH
`define VRC_CLK_MHZ 50
`define VRC_ROWS 256
`define VRC_REFRESH_MS 4
`define VRC_REFRESH_CYC ((`VRC_REFRESH_MS * 1000 * `VRC_CLK_MHZ) / `VRC_ROWS)
`define VRC_POWERUP_US 200
`define VRC_POWERUP_CYC (`VRC_POWERUP_US * `VRC_CLK_MHZ)
`define VRC_INIT_CYCLES 8
`define VRC_STROBE_CYC 4
`define VRC_SRD_CYC 4
// half period outlasts the four-cycle input synchroniser latency
`define VRC_SC_HALF 5
`define VRC_REG_CTRL 8'h00
`define VRC_REG_ADDR 8'h04
`define VRC_REG_WDATA 8'h08
`define VRC_REG_STATUS 8'h0C
`define VRC_REG_RDATA 8'h10
`define VRC_REG_SER 8'h14
`define VRC_CMD_NONE 3'h0
`define VRC_CMD_READ 3'h1
`define VRC_CMD_WRITE 3'h2
`define VRC_CMD_RDXFER 3'h3
`define VRC_CMD_WRXFER 3'h4
`define VRC_CMD_PSXFER 3'h5
`define VRC_CMD_SERIAL 3'h6
`define VRC_CMD_HIDDEN 3'h7
`endif

// File: vrc_pkg.sv
// types for the video dram controller
package vrc_pkg;
  typedef enum logic [3:0] {
    VRC_ST_POWERUP = 4'h0,
    VRC_ST_INIT = 4'h1,
    VRC_ST_IDLE = 4'h2,
    VRC_ST_ROW = 4'h3,
    VRC_ST_COL = 4'h4,
    VRC_ST_HOLD = 4'h5,
    VRC_ST_PRE = 4'h6,
    VRC_ST_CBR = 4'h7,
    VRC_ST_SRD = 4'h8
  } vrc_state_t;
  typedef logic [2:0] vrc_cmd_t;
endpackage : vrc_pkg

// File: vrc_sync.sv
// three-stage synchroniser for pin inputs
module vrc_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  genvar i;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end else if (clk_en) begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // a bit counts once stages two and three agree
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          q[i] <= 1'b0;
        end else if (clk_en && s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : vrc_sync

// File: vrc_apb.sv
// apb slave register file of the controller
`include "vrc_params.svh"
module vrc_apb (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] status,
  input wire logic [7:0] rdata,
  output logic [2:0] cmd,
  output logic cmd_valid,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic [7:0] wmask,
  output logic mask_en,
  output logic [7:0] ser_count
);
  logic acc;
  logic known;
  assign acc = psel && penable && clk_en;
  assign pready = 1'b1;
  assign known = (paddr <= `VRC_REG_SER) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !known;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= `VRC_CMD_NONE;
      cmd_valid <= 1'b0;
      addr <= 16'h0000;
      wdata <= 8'h00;
      wmask <= 8'hFF;
      mask_en <= 1'b0;
      ser_count <= 8'h00;
    end else if (clk_en) begin
      cmd_valid <= acc && pwrite && paddr == `VRC_REG_CTRL;
      if (acc && pwrite) begin
        case (paddr)
          `VRC_REG_CTRL: cmd <= pwdata[2:0];
          `VRC_REG_ADDR: addr <= pwdata[15:0];
          `VRC_REG_WDATA: begin
            wdata <= pwdata[7:0];
            wmask <= pwdata[15:8];
            mask_en <= pwdata[16];
          end
          `VRC_REG_SER: ser_count <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  always_comb begin
    case (paddr)
      `VRC_REG_CTRL: prdata = {29'h0, cmd};
      `VRC_REG_ADDR: prdata = {16'h0, addr};
      `VRC_REG_WDATA: prdata = {15'h0, mask_en, wmask, wdata};
      `VRC_REG_STATUS: prdata = status;
      `VRC_REG_RDATA: prdata = {24'h0, rdata};
      `VRC_REG_SER: prdata = {24'h0, ser_count};
      default: prdata = 32'h0;
    endcase
  end
endmodule : vrc_apb

// File: vrc_ctrl.sv
// host controller driving a dual-port video dram
// Summary of operation
// - refresh all 256 rows within every 4 ms
// - row-only refresh: row strobe falls with column strobe high, all rows (the controller refreshes by column-first cycles instead)
// - hidden refresh: hold column strobe low, cycle row strobe
// - read transfer: column high, enable low, mask/write high at row fall
// - write transfer: column high, enable, mask/write, serial enable low
// - back-to-back write transfers: hold serial clock until restart delay
// - pseudo write transfer: like write transfer with serial enable high
// - pseudo write transfer precedes a write transfer after a read transfer
// - hold serial clock during pseudo write until restart delay passes
// - wait 200 us after power-up, then 8 init cycles
// - init cycles are column-first refresh cycles
//
// Our own choices: the APB register port and the register addresses.
`include "vrc_params.svh"
module vrc_ctrl #(
  parameter int POWERUP_CYC = `VRC_POWERUP_CYC,
  parameter int REFRESH_CYC = `VRC_REFRESH_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic [7:0] ram_addr,
  output logic transfer_output_enable_n,
  output logic mask_write_enable_n,
  input wire logic [7:0] ram_data_mask_pins_in,
  output logic [7:0] ram_data_mask_pins_out,
  output logic [7:0] ram_data_mask_pins_oe,
  output logic serial_clock,
  output logic serial_enable_n,
  input wire logic [7:0] serial_data_pins_in,
  output logic [7:0] serial_data_pins_out,
  output logic [7:0] serial_data_pins_oe
);
  import vrc_pkg::*;

  vrc_state_t state_reg;
  vrc_cmd_t op_reg;
  logic [2:0] cmd;
  logic cmd_valid;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] wmask;
  logic mask_en;
  logic [7:0] ser_count;
  logic [7:0] dq_sync;
  logic [7:0] sdq_sync;
  logic [7:0] rdata_reg;
  logic [7:0] ser_data_reg;
  logic [15:0] wait_reg;
  logic [3:0] init_reg;
  logic [31:0] refresh_timer_reg;
  logic refresh_due_reg;
  logic [7:0] refresh_row_reg;
  logic serial_out_mode_reg;
  logic last_rdxfer_reg;
  logic transferred_reg;
  logic [8:0] ser_left_reg;
  logic [2:0] sc_div_reg;
  logic busy;
  logic ser_start;
  logic [31:0] status;
  logic refresh_done;

  function automatic logic is_xfer(input logic [2:0] c);
    is_xfer = (c == `VRC_CMD_RDXFER) || (c == `VRC_CMD_WRXFER) ||
      (c == `VRC_CMD_PSXFER);
  endfunction : is_xfer

  vrc_apb u_apb (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status),
    .rdata(rdata_reg),
    .cmd(cmd),
    .cmd_valid(cmd_valid),
    .addr(addr),
    .wdata(wdata),
    .wmask(wmask),
    .mask_en(mask_en),
    .ser_count(ser_count)
  );

  vrc_sync u_dq_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .d(ram_data_mask_pins_in),
    .q(dq_sync)
  );

  vrc_sync u_sdq_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .d(serial_data_pins_in),
    .q(sdq_sync)
  );

  assign busy = (state_reg != VRC_ST_IDLE) || (ser_left_reg != 9'h000);
  assign ser_start = (state_reg == VRC_ST_IDLE) && cmd_valid && (cmd == `VRC_CMD_SERIAL) &&
    transferred_reg && (ser_left_reg == 9'h000);
  assign status = {8'h00, ser_data_reg, 4'h0, serial_out_mode_reg, transferred_reg,
    refresh_due_reg, state_reg == VRC_ST_IDLE, 4'h0, busy, op_reg};
  assign refresh_done = (state_reg == VRC_ST_CBR) && (wait_reg == 16'h0000);

  // refresh interval timer, one row per slot keeps 256 rows inside 4 ms
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_timer_reg <= 32'h0;
      refresh_due_reg <= 1'b0;
    end else if (clk_en) begin
      if (refresh_timer_reg >= 32'(REFRESH_CYC - 1)) begin
        refresh_timer_reg <= 32'h0;
        refresh_due_reg <= 1'b1;
      end else begin
        refresh_timer_reg <= refresh_timer_reg + 32'h1;
        if (refresh_done) begin
          refresh_due_reg <= 1'b0;
        end
      end
    end
  end

  // main strobe sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= VRC_ST_POWERUP;
      op_reg <= `VRC_CMD_NONE;
      wait_reg <= 16'h0000;
      init_reg <= 4'h0;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      ram_addr <= 8'h00;
      transfer_output_enable_n <= 1'b1;
      mask_write_enable_n <= 1'b1;
      serial_enable_n <= 1'b1;
      ram_data_mask_pins_out <= 8'h00;
      ram_data_mask_pins_oe <= 8'h00;
      rdata_reg <= 8'h00;
      refresh_row_reg <= 8'h00;
      serial_out_mode_reg <= 1'b0;
      last_rdxfer_reg <= 1'b0;
      transferred_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        VRC_ST_POWERUP: begin
          if (wait_reg >= 16'(POWERUP_CYC - 1)) begin
            wait_reg <= 16'h0000;
            state_reg <= VRC_ST_INIT;
          end else begin
            wait_reg <= wait_reg + 16'h0001;
          end
        end
        VRC_ST_INIT: begin
          if (init_reg == 4'(`VRC_INIT_CYCLES)) begin
            state_reg <= VRC_ST_IDLE;
          end else begin
            init_reg <= init_reg + 4'h1;
            col_strobe_n <= 1'b0;
            wait_reg <= 16'(`VRC_STROBE_CYC);
            state_reg <= VRC_ST_CBR;
          end
        end
        VRC_ST_IDLE: begin
          // serial enable gates the serial outputs; this idle update holds it low only while the port is clocked
          serial_enable_n <= !(ser_start || ser_left_reg != 9'h000);
          // a command pulse lasts one cycle, so it goes ahead of a due refresh
          if (cmd_valid && cmd != `VRC_CMD_NONE && ser_left_reg == 9'h000 &&
              !(cmd == `VRC_CMD_SERIAL && !transferred_reg)) begin
            op_reg <= (cmd == `VRC_CMD_WRXFER && last_rdxfer_reg) ?
              `VRC_CMD_PSXFER : cmd;
            if (cmd == `VRC_CMD_SERIAL) begin
              op_reg <= `VRC_CMD_NONE;
            end else begin
              ram_addr <= addr[15:8];
              transfer_output_enable_n <= !is_xfer(cmd);
              mask_write_enable_n <= !(cmd == `VRC_CMD_WRXFER ||
                cmd == `VRC_CMD_PSXFER || (cmd == `VRC_CMD_WRITE && mask_en));
              serial_enable_n <= cmd == `VRC_CMD_PSXFER ||
                (cmd == `VRC_CMD_WRXFER && last_rdxfer_reg);
              ram_data_mask_pins_out <= wmask;
              ram_data_mask_pins_oe <= (cmd == `VRC_CMD_WRITE && mask_en) ? 8'hFF : 8'h00;
              wait_reg <= 16'(`VRC_STROBE_CYC);
              state_reg <= VRC_ST_ROW;
            end
          end else if (refresh_due_reg) begin
            // column low first selects the device's own refresh counter
            col_strobe_n <= 1'b0;
            wait_reg <= 16'(`VRC_STROBE_CYC);
            state_reg <= VRC_ST_CBR;
          end
        end
        VRC_ST_ROW: begin
          // row strobe falls with column high: row-only or transfer decode
          row_strobe_n <= 1'b0;
          if (wait_reg == 16'h0000) begin
            ram_addr <= addr[7:0];
            ram_data_mask_pins_oe <= 8'h00;
            if (op_reg == `VRC_CMD_WRITE) begin
              ram_data_mask_pins_out <= wdata;
              ram_data_mask_pins_oe <= 8'hFF;
              mask_write_enable_n <= 1'b0;
            end else if (op_reg == `VRC_CMD_READ || op_reg == `VRC_CMD_HIDDEN) begin
              mask_write_enable_n <= 1'b1;
              transfer_output_enable_n <= 1'b0;
            end
            wait_reg <= 16'(`VRC_STROBE_CYC);
            state_reg <= VRC_ST_COL;
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        VRC_ST_COL: begin
          col_strobe_n <= 1'b0;
          if (wait_reg == 16'h0000) begin
            if (is_xfer(op_reg)) begin
              transfer_output_enable_n <= 1'b1;
              serial_out_mode_reg <= op_reg == `VRC_CMD_RDXFER;
              // a pseudo write chained ahead of a write transfer keeps the chain marked
              last_rdxfer_reg <= op_reg == `VRC_CMD_RDXFER ||
                (op_reg == `VRC_CMD_PSXFER && cmd == `VRC_CMD_WRXFER);
              transferred_reg <= 1'b1;
            end
            wait_reg <= 16'(`VRC_STROBE_CYC);
            state_reg <= VRC_ST_HOLD;
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        VRC_ST_HOLD: begin
          // synchronised read data settles only four cycles after the column fall
          if (op_reg == `VRC_CMD_READ || op_reg == `VRC_CMD_HIDDEN) begin
            rdata_reg <= dq_sync;
          end
          row_strobe_n <= 1'b1;
          // hidden refresh keeps column and output enable low so the data stays
          col_strobe_n <= op_reg != `VRC_CMD_HIDDEN;
          transfer_output_enable_n <= op_reg != `VRC_CMD_HIDDEN;
          mask_write_enable_n <= 1'b1;
          serial_enable_n <= 1'b1;
          ram_data_mask_pins_oe <= 8'h00;
          wait_reg <= 16'(`VRC_SRD_CYC);
          // the chosen pseudo write is followed by the real write transfer
          if (op_reg == `VRC_CMD_PSXFER && cmd == `VRC_CMD_WRXFER) begin
            op_reg <= `VRC_CMD_WRXFER;
            state_reg <= VRC_ST_SRD;
          end else begin
            state_reg <= is_xfer(op_reg) ? VRC_ST_SRD : VRC_ST_PRE;
          end
        end
        VRC_ST_SRD: begin
          if (wait_reg == 16'h0000) begin
            if (op_reg == `VRC_CMD_WRXFER && last_rdxfer_reg) begin
              ram_addr <= addr[15:8];
              transfer_output_enable_n <= 1'b0;
              mask_write_enable_n <= 1'b0;
              serial_enable_n <= 1'b0;
              wait_reg <= 16'(`VRC_STROBE_CYC);
              state_reg <= VRC_ST_ROW;
            end else begin
              state_reg <= VRC_ST_IDLE;
            end
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        VRC_ST_CBR: begin
          if (wait_reg == 16'h0000) begin
            if (!row_strobe_n) begin
              row_strobe_n <= 1'b1;
              col_strobe_n <= 1'b1;
              refresh_row_reg <= refresh_row_reg + 8'h01;
              state_reg <= VRC_ST_PRE;
              wait_reg <= 16'(`VRC_STROBE_CYC);
            end else begin
              row_strobe_n <= 1'b0;
              wait_reg <= 16'(`VRC_STROBE_CYC);
            end
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        VRC_ST_PRE: begin
          if (wait_reg == 16'h0000) begin
            if (op_reg == `VRC_CMD_HIDDEN && row_strobe_n && !col_strobe_n) begin
              row_strobe_n <= 1'b0;
              wait_reg <= 16'(`VRC_STROBE_CYC);
            end else begin
              col_strobe_n <= 1'b1;
              row_strobe_n <= 1'b1;
              transfer_output_enable_n <= 1'b1;
              op_reg <= `VRC_CMD_NONE;
              state_reg <= (init_reg != 4'(`VRC_INIT_CYCLES)) ? VRC_ST_INIT : VRC_ST_IDLE;
            end
          end else begin
            wait_reg <= wait_reg - 16'h0001;
          end
        end
        default: state_reg <= VRC_ST_IDLE;
      endcase
    end
  end

  // serial port clocking, stopped while strobes run a transfer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_left_reg <= 9'h000;
      sc_div_reg <= 3'h0;
      serial_clock <= 1'b0;
      ser_data_reg <= 8'h00;
      serial_data_pins_out <= 8'h00;
      serial_data_pins_oe <= 8'h00;
    end else if (clk_en) begin
      if (ser_start) begin
        ser_left_reg <= {1'b0, ser_count} + 9'h001;
        serial_data_pins_out <= wdata;
        serial_data_pins_oe <= serial_out_mode_reg ? 8'h00 : 8'hFF;
      end else if (ser_left_reg != 9'h000) begin
        // a refresh only pauses the clock at its level, so no edge is added
        if (state_reg == VRC_ST_IDLE) begin
          if (sc_div_reg == 3'(`VRC_SC_HALF - 1)) begin
            sc_div_reg <= 3'h0;
            serial_clock <= !serial_clock;
            if (serial_clock) begin
              ser_left_reg <= ser_left_reg - 9'h001;
              if (serial_out_mode_reg) begin
                ser_data_reg <= sdq_sync;
              end
            end
          end else begin
            sc_div_reg <= sc_div_reg + 3'h1;
          end
        end
      end else begin
        serial_clock <= 1'b0;
        serial_data_pins_oe <= 8'h00;
      end
    end
  end

  a_cbr_col_first: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_reg == VRC_ST_CBR && $fell(row_strobe_n)) |-> !col_strobe_n)
    else $error("refresh row strobe fell without column low");
  a_xfer_col_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($fell(row_strobe_n) && is_xfer(op_reg)) |->
    (col_strobe_n && !transfer_output_enable_n))
    else $error("transfer decoded with column strobe low");
  a_sc_still_xfer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_reg == VRC_ST_SRD) |-> !serial_clock)
    else $error("serial clock moved during restart delay");
  a_pseudo_se: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($fell(row_strobe_n) && op_reg == `VRC_CMD_PSXFER) |-> serial_enable_n)
    else $error("pseudo write without serial enable high");
  a_write_se: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($fell(row_strobe_n) && op_reg == `VRC_CMD_WRXFER) |->
    (!serial_enable_n && !mask_write_enable_n))
    else $error("write transfer pin levels wrong");
  a_init_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state_reg == VRC_ST_IDLE) |-> init_reg == 4'(`VRC_INIT_CYCLES))
    else $error("idle before init cycles done");
  a_no_serial_early: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ser_left_reg != 9'h000) |-> transferred_reg)
    else $error("serial access before any transfer");
  a_refresh_due: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(refresh_due_reg) |-> ##[1:200] (state_reg == VRC_ST_CBR))
    else $error("refresh not started in time");
endmodule : vrc_ctrl

// File: vrc_dev.sv
// behavioural dual-port video dram answering the controller pins
module vrc_dev #(
  parameter realtime SRD_NS = 80
) (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [7:0] addr,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_c,
  input wire logic [7:0] dq_oe,
  output logic [7:0] dq,
  input wire logic sc,
  input wire logic se_n,
  input wire logic [7:0] sdq_c,
  input wire logic [7:0] sdq_oe,
  output logic [7:0] serial_data_pins
);
  logic [7:0] mem [65536];
  logic [7:0] serial_buffer [256];
  logic [7:0] row, col, mask;
  logic [7:0] q = 8'h00;
  logic [7:0] sq = 8'h00;
  logic [7:0] ptr = 'x; // unknown until a transfer loads it
  logic [7:0] rcnt = 8'h00;
  logic [2:0] kind = 3'h0; // 0 ram, 1 read xfer, 2 write xfer, 3 pseudo, 4 refresh
  logic mask_on;
  logic rd = 1'b0;
  logic ser_out = 1'b0;
  int cbr_n = 0, row_n = 0, xfer_n = 0, psx_n = 0, sc_n = 0, srd_err = 0, clash = 0;
  realtime t_ras = 0;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
  // released lines show the inverse of the last value, not a stale copy
  assign dq = (dq_oe & dq_c) | (~dq_oe & ((rd && !cas_n && !oe_n) ? q : ~q));
  assign serial_data_pins = (sdq_oe & sdq_c) | (~sdq_oe & ((ser_out && !se_n) ? sq : ~sq));
  function automatic void ram_wr();
    mem[{row, col}] = mask_on ? (mem[{row, col}] & ~mask) | (dq & mask) : dq;
  endfunction : ram_wr
  always @(negedge ras_n) begin
    t_ras = $realtime;
    row = addr;
    mask_on = 1'b0;
    if (!cas_n) begin
      kind = 3'h4;
      row = rcnt;
      rcnt++;
      cbr_n++;
    end else if (!oe_n) begin
      kind = we_n ? 3'h1 : (se_n ? 3'h3 : 3'h2);
      xfer_n++;
      psx_n += int'(kind == 3'h3);
      if (kind == 3'h2) for (int i = 0; i < 256; i++) mem[{row, 8'(i)}] = serial_buffer[i];
    end else begin
      kind = 3'h0;
      row_n++;
      mask_on = !we_n;
      mask = dq;
    end
  end
  always @(negedge cas_n) if (!ras_n && kind != 3'h4) begin
    col = addr;
    if (kind != 3'h0) ptr = col;
    else if (!we_n) ram_wr();
    else begin
      q = mem[{row, col}];
      rd = 1'b1;
    end
  end
  always @(negedge we_n) if (!ras_n && !cas_n && kind == 3'h0) ram_wr();
  always @(posedge cas_n) rd = 1'b0;
  always @(posedge oe_n) if (!ras_n && kind inside {3'h1, 3'h2, 3'h3}) begin
    if (kind == 3'h1) for (int i = 0; i < 256; i++) serial_buffer[i] = mem[{row, 8'(i)}];
    ser_out = (kind == 3'h1);
  end
  always @(dq_oe, rd, cas_n, oe_n) if (|dq_oe && rd && !cas_n && !oe_n) clash++;
  always @(posedge sc) begin
    sc_n++;
    if (kind inside {3'h2, 3'h3} && $realtime - t_ras < SRD_NS) srd_err++;
    if (ser_out) sq = serial_buffer[ptr];
    else serial_buffer[ptr] = serial_data_pins;
    ptr++;
  end
endmodule : vrc_dev

// File: tb_dual_port_video_dram_ops.sv
// self-checking bench: controller against a behavioural video dram
`include "vrc_params.svh"
`define chk(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb_dual_port_video_dram_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ras_n, cas_n, oe_n, we_n, sc, se_n;
  logic [7:0] ma, dq, dq_c, dq_oe, serial_data_pins, sdq_c, sdq_oe;
  int err_count = 0, checks = 0, cyc = 0, n0;
  vrc_ctrl #(.POWERUP_CYC(20), .REFRESH_CYC(300)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .row_strobe_n(ras_n), .col_strobe_n(cas_n), .ram_addr(ma),
    .transfer_output_enable_n(oe_n), .mask_write_enable_n(we_n),
    .ram_data_mask_pins_in(dq), .ram_data_mask_pins_out(dq_c), .ram_data_mask_pins_oe(dq_oe),
    .serial_clock(sc), .serial_enable_n(se_n), .serial_data_pins_in(serial_data_pins),
    .serial_data_pins_out(sdq_c), .serial_data_pins_oe(sdq_oe));
  vrc_dev u_dev (.ras_n(ras_n), .cas_n(cas_n), .addr(ma), .oe_n(oe_n), .we_n(we_n),
    .dq_c(dq_c), .dq_oe(dq_oe), .dq(dq), .sc(sc), .se_n(se_n), .sdq_c(sdq_c),
    .sdq_oe(sdq_oe), .serial_data_pins(serial_data_pins));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // a command written while busy is dropped, so wait for idle before and after
  task automatic cmd(input logic [2:0] c);
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, `VRC_REG_STATUS, 32'h0);
      if (rd[3] === 1'b0) break;
    end
    apb(1'b1, `VRC_REG_CTRL, {29'h0, c});
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, `VRC_REG_STATUS, 32'h0);
      if (rd[3] === 1'b0) break;
    end
  endtask : cmd
  task automatic t_init;
    repeat (18) @(posedge sys_clk);
    `chk(u_dev.cbr_n + u_dev.row_n, 0)
    while (u_dev.cbr_n < 8) @(posedge sys_clk);
    repeat (60) @(posedge sys_clk);
    `chk({u_dev.cbr_n, u_dev.row_n}, {32'd8, 32'd0})
  endtask : t_init
  task automatic t_early_serial;
    apb(1'b1, `VRC_REG_SER, 32'h3);
    cmd(`VRC_CMD_SERIAL);
    `chk(u_dev.sc_n, 0)
  endtask : t_early_serial
  task automatic t_ram;
    apb(1'b1, `VRC_REG_ADDR, 32'h1234);
    apb(1'b1, `VRC_REG_WDATA, 32'hA5);
    cmd(`VRC_CMD_WRITE);
    `chk(u_dev.mem[16'h1234], 8'hA5)
    apb(1'b1, `VRC_REG_WDATA, 32'h1_0F3C);
    cmd(`VRC_CMD_WRITE);
    `chk(u_dev.mem[16'h1234], 8'hAC)
    apb(1'b1, `VRC_REG_WDATA, 32'h1_00FF);
    cmd(`VRC_CMD_WRITE);
    `chk(u_dev.mem[16'h1234], 8'hAC)
    cmd(`VRC_CMD_READ);
    apb(1'b0, `VRC_REG_RDATA, 32'h0);
    `chk(rd[7:0], 8'hAC)
  endtask : t_ram
  task automatic t_rdxfer;
    apb(1'b1, `VRC_REG_ADDR, 32'h21FE);
    cmd(`VRC_CMD_RDXFER);
    `chk({u_dev.ser_out, u_dev.ptr}, {1'b1, 8'hFE})
    apb(1'b1, `VRC_REG_SER, 32'h2);
    cmd(`VRC_CMD_SERIAL);
    apb(1'b0, `VRC_REG_STATUS, 32'h0);
    `chk({rd[23:16], rd[11]}, {8'h21, 1'b1})
    `chk(u_dev.ptr, 8'h01)
  endtask : t_rdxfer
  task automatic t_wrxfer;
    n0 = u_dev.psx_n;
    apb(1'b1, `VRC_REG_ADDR, 32'h3310);
    cmd(`VRC_CMD_WRXFER);
    `chk(u_dev.psx_n, n0 + 1)
    `chk({u_dev.mem[16'h3310], u_dev.ser_out}, {8'h31, 1'b0})
    apb(1'b1, `VRC_REG_ADDR, 32'h3410);
    cmd(`VRC_CMD_WRXFER);
    `chk({u_dev.psx_n, 24'h0, u_dev.mem[16'h3410]}, {n0 + 1, 32'h31})
    apb(1'b1, `VRC_REG_SER, 32'h1);
    cmd(`VRC_CMD_SERIAL);
    `chk(u_dev.srd_err, 0)
  endtask : t_wrxfer
  task automatic t_hidden;
    // start right after a timed refresh so only the hidden one is counted
    n0 = u_dev.cbr_n;
    while (u_dev.cbr_n == n0) @(posedge sys_clk);
    n0 = u_dev.cbr_n;
    apb(1'b1, `VRC_REG_ADDR, 32'h0102);
    cmd(`VRC_CMD_HIDDEN);
    `chk(u_dev.cbr_n, n0 + 1)
    apb(1'b0, `VRC_REG_RDATA, 32'h0);
    `chk(rd[7:0], 8'h03)
    `chk(u_dev.clash, 0)
  endtask : t_hidden
  task automatic t_refresh;
    n0 = u_dev.cbr_n + u_dev.row_n;
    repeat (700) @(posedge sys_clk);
    `chk(u_dev.cbr_n + u_dev.row_n - n0 >= 2, 1'b1)
  endtask : t_refresh
  task automatic t_badaddr;
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    `chk(er, 1'b1)
    apb(1'b0, 8'h3C, 32'h0);
    `chk({er, rd}, {1'b1, 32'h0})
    apb(1'b0, 8'h05, 32'h0);
    `chk(er, 1'b1)
  endtask : t_badaddr
  task automatic finish_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ceiling well above power-up, init and all command sequences
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_init();
    t_early_serial();
    t_ram();
    t_rdxfer();
    t_wrxfer();
    t_hidden();
    t_refresh();
    t_badaddr();
    finish_test();
  end
endmodule : tb_dual_port_video_dram_ops
